// ---- logic/irqvh_pkg.sv ----
// irqvh_pkg: constants, types and helpers for the interrupt mapping and halt/wake-up block.
// Assumes one CPU clock domain; all users import the whole package.
package irqvh_pkg;

	// source slots and hardware order
	localparam int              NUM_SRC      = 14;
	localparam int              NUM_EXT      = 4;
	localparam int              SRC_W        = 4;
	localparam logic [SRC_W-1:0] SRC_TLI      = 4'h0;
	localparam logic [SRC_W-1:0] SRC_TIMEBASE = 4'h1;
	localparam logic [SRC_W-1:0] SRC_EXT0     = 4'h2;
	localparam logic [SRC_W-1:0] SRC_UNUSED   = 4'h6;
	localparam logic [SRC_W-1:0] SRC_SPI      = 4'h7;
	localparam logic [SRC_W-1:0] SRC_TIM_A    = 4'h8;
	localparam logic [SRC_W-1:0] SRC_TIM_B    = 4'h9;
	localparam logic [SRC_W-1:0] SRC_SERIAL   = 4'hA;
	localparam logic [SRC_W-1:0] SRC_AVD      = 4'hB;
	localparam logic [SRC_W-1:0] SRC_I2C      = 4'hC;
	localparam logic [SRC_W-1:0] SRC_ART      = 4'hD;

	// vector addresses (low byte of each pair)
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
	localparam logic [15:0] VEC_TOP   = 16'hFFFA;
	localparam logic [15:0] VEC_STEP  = 16'h0002;

	// priority mask codes {high,low} and the level each one means
	localparam logic [1:0] MASK_LVL0 = 2'h2;
	localparam logic [1:0] MASK_LVL1 = 2'h0;
	localparam logic [1:0] MASK_LVL2 = 2'h1;
	localparam logic [1:0] MASK_LVL3 = 2'h3;

	// external sense select codes
	localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
	localparam logic [1:0] SENSE_RISE     = 2'h1;
	localparam logic [1:0] SENSE_FALL     = 2'h2;
	localparam logic [1:0] SENSE_BOTH     = 2'h3;
	localparam logic       PIN_IDLE       = 1'b1;

	// oscillator start-up delays in CPU cycles
	localparam int              STARTUP_W     = 13;
	localparam logic [STARTUP_W-1:0] STARTUP_SHORT = 13'h0100;
	localparam logic [STARTUP_W-1:0] STARTUP_LONG  = 13'h1000;

	localparam int STACK_DEPTH = 4;

	typedef struct packed {
		logic            pol_b;
		logic            pol_a;
		logic [3:0][1:0] sel;
	} irqvh_sense_cfg_t;

	typedef struct packed {
		logic wdg_enabled;
		logic wdg_halt_allow;
		logic osc_irq_enable;
		logic startup_long;
	} irqvh_halt_cfg_t;

	typedef struct packed {
		logic spi_slave;
		logic art_ext_clk;
	} irqvh_wake_cfg_t;

	typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STARTUP} irqvh_state_t;

	function automatic logic [1:0] irqvh_code2lvl(input logic [1:0] code);
		case (code)
			MASK_LVL0: irqvh_code2lvl = 2'h0;
			MASK_LVL1: irqvh_code2lvl = 2'h1;
			MASK_LVL2: irqvh_code2lvl = 2'h2;
			default:   irqvh_code2lvl = 2'h3;
		endcase
	endfunction : irqvh_code2lvl

	function automatic logic [1:0] irqvh_lvl2code(input logic [1:0] lvl);
		case (lvl)
			2'h0:    irqvh_lvl2code = MASK_LVL0;
			2'h1:    irqvh_lvl2code = MASK_LVL1;
			2'h2:    irqvh_lvl2code = MASK_LVL2;
			default: irqvh_lvl2code = MASK_LVL3;
		endcase
	endfunction : irqvh_lvl2code

endpackage : irqvh_pkg

// ---- logic/irqvh_ext_sense.sv ----
// irqvh_ext_sense: one external interrupt pin, synchronised, with selectable sensitivity.
// Assumes an asynchronous pin idling high and a clear pulse from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module irqvh_ext_sense import irqvh_pkg::*; #(
	parameter bit HAS_POL = 1'b0
) (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// pin and configuration
	input  wire logic       i_pin,
	input  wire logic [1:0] i_sel,
	input  wire logic       i_pol,
	input  wire logic       i_clear,
	// pending flag
	output logic            o_pending
);

	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic fall;
	logic rise;
	logic set_ev;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1_q <= PIN_IDLE;
			sync2_q <= PIN_IDLE;
			prev_q  <= PIN_IDLE;
		end else begin
			sync1_q <= i_pin;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	assign fall = prev_q & ~sync2_q;
	assign rise = ~prev_q & sync2_q;

	always_comb begin
		case (i_sel)
			SENSE_RISE: set_ev = rise;
			SENSE_FALL: set_ev = fall;
			SENSE_BOTH: set_ev = rise | fall;
			default: begin
				// polarity turns falling+low into rising+high where supported
				if (HAS_POL && i_pol)
					set_ev = rise | sync2_q;
				else
					set_ev = fall | ~sync2_q;
			end
		endcase
	end

	// set wins over clear
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_pending <= 1'b0;
		else if (set_ev)
			o_pending <= 1'b1;
		else if (i_clear)
			o_pending <= 1'b0;
	end

	AST_EXT_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
		i_clear && !set_ev |=> !o_pending) else $error("pending not cleared");
	AST_EXT_SET: assert property (@(posedge i_clk) disable iff (i_rst)
		set_ev |=> o_pending) else $error("sense event lost");

endmodule : irqvh_ext_sense

`default_nettype wire

// ---- logic/irqvh_ctrl.sv ----
// irqvh_ctrl: interrupt mapping, priority grant, mask stacking and halt/wake-up control.
// Assumes the CPU acks a request with a one-cycle pulse and peripherals hold level requests.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - line interrupt: vector FFFA, top priority, wakes
// - time base: vector FFF8, wakes halt
// - four port groups FFF6 down to FFF0, wake
// - SPI FFEC, wakes only as slave
// - timers FFEA and FFE8, never wake
// - serial, voltage, I2C FFE6-FFE2, never wake
// - auto-reload timer FFE0, wakes on external clock
// - equal level: lowest source number wins
// - four groups with independent sensitivity
// - fall, rise, both, fall+low; rise+high groups 0,2
// - changed sense setting clears pending external flags
// - halt entered only with oscillator irq disabled
// - wake restarts oscillator, waits 256/4096 cycles
// - halt entry forces mask to 10b
// - halt stops oscillator and peripheral clocks
// - watchdog forbidding halt: halt gives watchdog reset
// - entry pushes mask, sets level; pop restores
module irqvh_ctrl import irqvh_pkg::*; #(
	parameter int DEPTH = STACK_DEPTH
) (
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// interrupt sources
	input  wire logic                   i_top_level_line_irq,
	input  wire logic [NUM_EXT-1:0]     i_ext_group,
	input  wire logic [NUM_SRC-1:0]     i_periph_req,
	input  wire logic [NUM_SRC-1:0][1:0] i_src_level,
	// configuration
	input  wire logic                   i_sense_wr,
	input  wire irqvh_sense_cfg_t       i_ext_sense_control,
	input  wire logic [1:0]             i_tli_sel,
	input  wire irqvh_halt_cfg_t        i_halt_cfg,
	input  wire irqvh_wake_cfg_t        i_wake_cfg,
	// cpu side
	input  wire logic                   i_irq_ack,
	input  wire logic                   i_trap,
	input  wire logic                   i_cc_pop,
	input  wire logic                   i_mask_wr,
	input  wire logic [1:0]             i_mask_wdata,
	input  wire logic                   i_halt_exec,
	// grant
	output logic                        o_irq_req,
	output logic [SRC_W-1:0]            o_src_id,
	output logic [15:0]                 o_vector,
	output logic                        o_trap_go,
	output logic                        o_reset_fetch,
	output logic [1:0]                  o_prio_mask,
	// power
	output logic                        o_halted,
	output logic                        o_osc_run,
	output logic                        o_periph_clk_en,
	output logic                        o_cpu_run,
	output logic                        o_wdg_reset,
	output logic [NUM_EXT:0]            o_ext_pending
);

	irqvh_state_t             state_q;
	irqvh_state_t             state_d;
	irqvh_sense_cfg_t         sense_q;
	logic [1:0]               tli_sel_q;
	logic                     sense_change;
	logic [NUM_EXT:0]         ext_pend;
	logic [NUM_EXT:0]         ext_clear;
	logic [NUM_SRC-1:0]       req;
	logic [NUM_SRC-1:0]       wake_cap;
	logic                     wake_any;
	logic                     best_valid;
	logic [SRC_W-1:0]         best_idx;
	logic [1:0]               best_lvl;
	logic [1:0]               cur_lvl;
	logic                     ack_ok;
	logic [1:0]               ack_lvl;
	logic [STARTUP_W-1:0]     cnt_q;
	logic [STARTUP_W-1:0]     delay_lim;
	logic                     from_reset_q;
	logic                     halt_ok;
	logic                     wdg_block;
	logic [DEPTH-1:0][1:0]    stack_q;
	logic [$clog2(DEPTH):0]   sp_q;
	logic [$clog2(DEPTH)-1:0] push_idx;
	logic [$clog2(DEPTH)-1:0] pop_idx;

	// external sense configuration; software keeps writes to level 3
	assign sense_change = i_sense_wr && (i_ext_sense_control != sense_q || i_tli_sel != tli_sel_q);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sense_q   <= '0;
			tli_sel_q <= SENSE_FALL;
		end else if (i_sense_wr) begin
			sense_q   <= i_ext_sense_control;
			tli_sel_q <= i_tli_sel;
		end
	end

	// ack clears the granted edge flag; a changed setting clears all
	assign ack_ok = i_irq_ack && o_irq_req;

	always_comb begin
		for (int g = 0; g <= NUM_EXT; g++) begin
			ext_clear[g] = sense_change;
		end
		if (ack_ok && o_src_id == SRC_TLI)
			ext_clear[0] = 1'b1;
		for (int g = 0; g < NUM_EXT; g++) begin
			if (ack_ok && o_src_id == SRC_W'(int'(SRC_EXT0) + g))
				ext_clear[g+1] = 1'b1;
		end
	end

	irqvh_ext_sense #(.HAS_POL(1'b0)) u_tli (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_pin     (i_top_level_line_irq),
		.i_sel     (tli_sel_q),
		.i_pol     (1'b0),
		.i_clear   (ext_clear[0]),
		.o_pending (ext_pend[0])
	);

	// groups 0 and 2 sit on the ports with a polarity bit
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
			irqvh_ext_sense #(.HAS_POL(gi == 0 || gi == 2)) u_sense (
				.i_clk     (i_clk),
				.i_rst     (i_rst),
				.i_pin     (i_ext_group[gi]),
				.i_sel     (sense_q.sel[gi]),
				.i_pol     ((gi < 2) ? sense_q.pol_a : sense_q.pol_b),
				.i_clear   (ext_clear[gi+1]),
				.o_pending (ext_pend[gi+1])
			);
		end
	endgenerate

	// request vector and halt wake capability
	always_comb begin
		req = i_periph_req;
		req[SRC_TLI] = ext_pend[0];
		for (int g = 0; g < NUM_EXT; g++) begin
			req[int'(SRC_EXT0) + g] = ext_pend[g+1];
		end
		req[SRC_UNUSED] = 1'b0;
		wake_cap = '0;
		wake_cap[SRC_TLI] = 1'b1;
		wake_cap[SRC_TIMEBASE] = 1'b1;
		for (int g = 0; g < NUM_EXT; g++) begin
			wake_cap[int'(SRC_EXT0) + g] = 1'b1;
		end
		wake_cap[SRC_SPI] = i_wake_cfg.spi_slave;
		wake_cap[SRC_ART] = i_wake_cfg.art_ext_clk;
		// timers, serial, voltage detector and I2C stay zero
	end

	assign wake_any = |(req & wake_cap);
	assign cur_lvl  = irqvh_code2lvl(o_prio_mask);

	// highest software level first, then lowest source number
	always_comb begin
		best_valid = 1'b0;
		best_idx   = '0;
		best_lvl   = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req[i] && i_src_level[i] > cur_lvl && (!best_valid || i_src_level[i] >= best_lvl)) begin
				best_valid = 1'b1;
				best_idx   = SRC_W'(i);
				best_lvl   = i_src_level[i];
			end
		end
	end

	// halt control
	assign wdg_block = i_halt_cfg.wdg_enabled && !i_halt_cfg.wdg_halt_allow;
	assign halt_ok   = i_halt_exec && !wdg_block && !i_halt_cfg.osc_irq_enable;
	assign delay_lim = i_halt_cfg.startup_long ? STARTUP_LONG : STARTUP_SHORT;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (halt_ok)
					state_d = ST_HALT;
			end
			ST_HALT: begin
				if (wake_any)
					state_d = ST_STARTUP;
			end
			ST_STARTUP: begin
				if (cnt_q >= delay_lim - 1'b1)
					state_d = ST_RUN;
			end
			default: state_d = ST_RUN;
		endcase
	end

	// reset counts as a wake: it runs the start-up delay too
	always_ff @(posedge i_clk) begin
		if (i_rst)
			state_q <= ST_STARTUP;
		else
			state_q <= state_d;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			cnt_q <= '0;
		else if (state_q == ST_STARTUP)
			cnt_q <= cnt_q + 1'b1;
		else
			cnt_q <= '0;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			from_reset_q <= 1'b1;
		else if (state_q == ST_STARTUP && state_d == ST_RUN)
			from_reset_q <= 1'b0;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_halted        <= 1'b0;
			o_osc_run       <= 1'b1;
			o_periph_clk_en <= 1'b0;
			o_cpu_run       <= 1'b0;
		end else begin
			o_halted        <= (state_d == ST_HALT);
			o_osc_run       <= (state_d != ST_HALT);
			o_periph_clk_en <= (state_d != ST_HALT);
			o_cpu_run       <= (state_d == ST_RUN);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_wdg_reset <= 1'b0;
		else
			o_wdg_reset <= (state_q == ST_RUN) && i_halt_exec && wdg_block;
	end

	// grant and vector
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_irq_req     <= 1'b0;
			o_src_id      <= '0;
			o_vector      <= VEC_RESET;
			o_trap_go     <= 1'b0;
			o_reset_fetch <= 1'b0;
		end else begin
			o_reset_fetch <= 1'b0;
			o_trap_go     <= 1'b0;
			o_irq_req     <= (state_q == ST_RUN) && best_valid && !ack_ok && !i_trap;
			if (state_q == ST_STARTUP && state_d == ST_RUN && from_reset_q) begin
				o_reset_fetch <= 1'b1;
				o_irq_req     <= 1'b0;
				o_vector      <= VEC_RESET;
			end else if (state_q == ST_RUN && i_trap) begin
				o_trap_go <= 1'b1;
				o_vector  <= VEC_TRAP;
			end else if (best_valid) begin
				o_src_id <= best_idx;
				o_vector <= 16'(VEC_TOP - VEC_STEP * 16'(best_idx));
			end
		end
	end

	// priority mask and its stack
	assign ack_lvl = i_src_level[o_src_id];

	// a full stack keeps overwriting its top entry
	assign push_idx = (sp_q == ($clog2(DEPTH)+1)'(DEPTH)) ? ($clog2(DEPTH))'(DEPTH - 1) : sp_q[$clog2(DEPTH)-1:0];
	assign pop_idx  = ($clog2(DEPTH))'(sp_q - 1'b1);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_prio_mask <= MASK_LVL3;
			sp_q        <= '0;
			stack_q     <= '0;
		end else if (state_q == ST_RUN && state_d == ST_HALT) begin
			o_prio_mask <= MASK_LVL0;
		end else if (ack_ok || (state_q == ST_RUN && i_trap)) begin
			stack_q[push_idx] <= o_prio_mask;
			if (sp_q < ($clog2(DEPTH)+1)'(DEPTH))
				sp_q <= sp_q + 1'b1;
			o_prio_mask <= ack_ok ? irqvh_lvl2code(ack_lvl) : MASK_LVL3;
		end else if (i_cc_pop && sp_q != '0) begin
			o_prio_mask <= stack_q[pop_idx];
			sp_q        <= sp_q - 1'b1;
		end else if (i_mask_wr) begin
			o_prio_mask <= i_mask_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_ext_pending <= '0;
		else
			o_ext_pending <= ext_pend;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	AST_SLOT6_SILENT: assert property (o_irq_req |-> o_src_id != SRC_UNUSED)
		else $error("request raised in unused slot");
	AST_VECTOR_MAP: assert property (o_irq_req |-> o_vector == 16'(VEC_TOP - VEC_STEP * 16'(o_src_id)))
		else $error("vector does not match source");
	AST_HALT_MASK: assert property (state_q == ST_RUN && halt_ok |=> o_halted && o_prio_mask == MASK_LVL0)
		else $error("halt entry did not force mask");
	AST_OIE_BLOCKS: assert property (state_q == ST_RUN && i_halt_exec && i_halt_cfg.osc_irq_enable |=> !o_halted)
		else $error("halt entered with oscillator irq enabled");
	AST_WDG_RESET: assert property (state_q == ST_RUN && i_halt_exec && wdg_block |=> o_wdg_reset && !o_halted)
		else $error("halt not turned into watchdog reset");
	AST_OSC_STOP: assert property (o_halted |-> !o_osc_run && !o_periph_clk_en)
		else $error("clocks run during halt");
	AST_NO_WAKE: assert property (state_q == ST_HALT && !(|(req & wake_cap)) |=> state_q == ST_HALT)
		else $error("halt left without wake source");
	AST_STARTUP_LEN: assert property (state_q == ST_STARTUP && cnt_q < delay_lim - 1'b1 |=> !o_cpu_run)
		else $error("cpu resumed before start-up delay");
	AST_ACK_LEVEL: assert property (ack_ok && !halt_ok |=> o_prio_mask == irqvh_lvl2code($past(ack_lvl)))
		else $error("mask not set to routine level");
	// a grantable source that should have beaten the winner
	logic tie_lost;
	always_comb begin
		tie_lost = 1'b0;
		for (int j = 0; j < NUM_SRC; j++) begin
			if (req[j] && i_src_level[j] > cur_lvl) begin
				if (j < int'(best_idx) && i_src_level[j] >= best_lvl)
					tie_lost = 1'b1;
				if (j > int'(best_idx) && i_src_level[j] > best_lvl)
					tie_lost = 1'b1;
			end
		end
	end

	AST_TIE_LOW: assert property (best_valid |-> !tie_lost)
		else $error("grant passed over a stronger source");

	COV_WAKE: cover property (state_q == ST_HALT ##1 state_q == ST_STARTUP);
	COV_ACK: cover property (o_irq_req && i_irq_ack);
	COV_WDG: cover property (o_wdg_reset);
	COV_SENSE: cover property (sense_change && |ext_pend);

endmodule : irqvh_ctrl

`default_nettype wire

// ---- sim/irqvh_cpu_model.sv ----
// irqvh_cpu_model: cpu core stand-in that acknowledges shown requests.
// Assumes the block's one-cycle ack contract; the pacing delay comes from the bench.
`timescale 1ns/1ps
`default_nettype none

module irqvh_cpu_model (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// request and pacing
	input  wire logic       i_req,
	input  wire logic [3:0] i_dly,
	// acknowledge
	output logic            o_ack
);
	logic [3:0] wait_q;

	// ack only while a request is shown, one cycle long
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_req || o_ack) begin
			wait_q <= 4'h0;
			o_ack  <= 1'h0;
		end else if (wait_q == i_dly) begin
			o_ack <= 1'h1;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule : irqvh_cpu_model

`default_nettype wire

// ---- sim/testbench.sv ----
// testbench: scenario tasks for the interrupt mapping and halt/wake-up block.
// Assumes irqvh_cpu_model acks requests; everything else is driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, g, n) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end

module testbench import irqvh_pkg::*; ;
	logic                    i_clk = 1'h0;
	logic                    i_rst = 1'h1;
	logic                    top_level_line_irq   = 1'h1;
	logic [NUM_EXT-1:0]      grp   = '1;
	logic [NUM_SRC-1:0]      preq  = '0;
	logic [NUM_SRC-1:0][1:0] lvl   = {NUM_SRC{2'h1}};
	logic [4:0]              pv    = '0;
	irqvh_sense_cfg_t        sc    = '0;
	irqvh_halt_cfg_t         hc    = '0;
	irqvh_wake_cfg_t         wc    = '0;
	logic [1:0]              mwd   = MASK_LVL0;
	logic [1:0]              ts    = SENSE_FALL;
	logic [3:0]              dly   = 4'h0;
	logic                    ack, req, trg, rf, hlt, osc, pce, run, wdr;
	logic [SRC_W-1:0]        sid;
	logic [15:0]             vec;
	logic [1:0]              pm;
	logic [NUM_EXT:0]        pend;
	logic [3:0]              vs [6] = '{4'h1, 4'h7, 4'h9, 4'hA, 4'hB, 4'hD};
	int                      err_count   = 0;
	int                      check_count = 0;
	int                      nc;

	always #2 i_clk = ~i_clk;

	irqvh_ctrl dut (
		.i_clk(i_clk), .i_rst(i_rst),
		.i_top_level_line_irq(top_level_line_irq), .i_ext_group(grp), .i_periph_req(preq), .i_src_level(lvl),
		.i_sense_wr(pv[4]), .i_ext_sense_control(sc), .i_tli_sel(ts),
		.i_halt_cfg(hc), .i_wake_cfg(wc), .i_irq_ack(ack), .i_trap(pv[2]), .i_cc_pop(pv[1]),
		.i_mask_wr(pv[0]), .i_mask_wdata(mwd), .i_halt_exec(pv[3]),
		.o_irq_req(req), .o_src_id(sid), .o_vector(vec), .o_trap_go(trg), .o_reset_fetch(rf),
		.o_prio_mask(pm), .o_halted(hlt), .o_osc_run(osc), .o_periph_clk_en(pce), .o_cpu_run(run),
		.o_wdg_reset(wdr), .o_ext_pending(pend)
	);

	irqvh_cpu_model cpu (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_dly(dly), .o_ack(ack));

	function automatic logic sg(input int k);
		case (k)
			0: sg = req;
			1: sg = run;
			2: sg = osc;
			3: sg = rf;
			default: sg = ~req;
		endcase
	endfunction : sg

	// counts edges until the chosen flag is seen high
	task automatic wt(input int k, input int lim);
		nc = 0;
		do begin
			@(negedge i_clk);
			nc++;
			if (nc > lim) begin
				err_count++;
				$display("[ERR] wait %0d exp 1 got timeout", k);
				end_sim();
			end
		end while (sg(k) !== 1'h1);
	endtask : wt

	// pulse bits: 0 mask write, 1 pop, 2 trap, 3 halt, 4 sense write
	task automatic pl(input int k);
		@(posedge i_clk);
		pv <= 5'h01 << k;
		@(posedge i_clk);
		pv <= '0;
	endtask : pl

	task automatic sm(input logic [1:0] c);
		@(posedge i_clk);
		mwd <= c;
		pl(0);
	endtask : sm

	// one grant: vector, entry mask, release, pop
	task automatic gr(input logic [3:0] s);
		wt(0, 40);
		`CHK(s, sid, "source")
		`CHK(16'hFFFA - {11'h0, s, 1'h0}, vec, "vector")
		wt(4, 40);
		`CHK(MASK_LVL1, pm, "mask on entry")
		@(posedge i_clk);
		preq[s] <= 1'h0;
		top_level_line_irq     <= 1'h1;
		grp     <= '1;
		pl(1);
		@(negedge i_clk);
		`CHK(MASK_LVL0, pm, "mask on pop")
	endtask : gr

	task automatic t_ext();
		@(posedge i_clk);
		sc.sel <= {SENSE_BOTH, SENSE_FALL, SENSE_RISE, SENSE_FALL};
		pl(4);
		sm(MASK_LVL0);
		grp[0] <= 1'h0;
		gr(4'h2);
		@(posedge i_clk);
		grp[1] <= 1'h0;
		repeat (10) @(negedge i_clk);
		`CHK(1'h0, req, "fall in rise mode")
		@(posedge i_clk);
		grp[1] <= 1'h1;
		gr(4'h3);
		@(posedge i_clk);
		grp[2] <= 1'h0;
		gr(4'h4);
		@(posedge i_clk);
		grp[3] <= 1'h0;
		gr(4'h5);
		gr(4'h5);
	endtask : t_ext

	task automatic t_prio();
		sm(MASK_LVL3);
		top_level_line_irq      <= 1'h0;
		preq[1]  <= 1'h1;
		preq[8]  <= 1'h1;
		preq[12] <= 1'h1;
		repeat (10) @(negedge i_clk);
		`CHK(1'h0, req, "masked at level 3")
		sm(MASK_LVL0);
		gr(4'h0);
		gr(4'h1);
		gr(4'h8);
		gr(4'hC);
		@(posedge i_clk);
		preq[6] <= 1'h1;
		repeat (10) @(negedge i_clk);
		`CHK(1'h0, req, "slot 6")
		@(posedge i_clk);
		preq[6] <= 1'h0;
		dly     <= 4'h3;
		foreach (vs[i]) begin
			@(posedge i_clk);
			preq[vs[i]] <= 1'h1;
			gr(vs[i]);
		end
	endtask : t_prio

	task automatic t_clear();
		sm(MASK_LVL3);
		grp[2] <= 1'h0;
		repeat (8) @(negedge i_clk);
		`CHK(5'h08, pend, "pending set")
		pl(4);
		repeat (3) @(negedge i_clk);
		`CHK(5'h08, pend, "same value keeps")
		@(posedge i_clk);
		sc.sel[0] <= SENSE_FALL_LOW;
		grp[2]    <= 1'h1;
		pl(4);
		repeat (3) @(negedge i_clk);
		`CHK(5'h00, pend, "pending cleared")
		@(posedge i_clk);
		grp[2] <= 1'h0;
		repeat (8) @(negedge i_clk);
		`CHK(5'h08, pend, "pending set again")
		@(posedge i_clk);
		ts     <= SENSE_BOTH;
		grp[2] <= 1'h1;
		pl(4);
		repeat (3) @(negedge i_clk);
		`CHK(5'h00, pend, "line sense change clears")
		sm(MASK_LVL0);
		repeat (8) @(negedge i_clk);
		`CHK(1'h0, req, "no stale request")
		pl(2);
		@(negedge i_clk);
		`CHK(3'h7, {trg, pm}, "trap entry")
		`CHK(16'hFFFC, vec, "trap vector")
		pl(1);
		@(negedge i_clk);
		`CHK(MASK_LVL0, pm, "trap pop")
	endtask : t_clear

	task automatic t_halt();
		@(posedge i_clk);
		hc.osc_irq_enable <= 1'h1;
		pl(3);
		repeat (4) @(negedge i_clk);
		`CHK(1'h0, hlt, "halt with osc irq")
		@(posedge i_clk);
		hc <= 4'h8;
		pl(3);
		@(negedge i_clk);
		`CHK(2'h2, {wdr, hlt}, "watchdog instead")
		sm(MASK_LVL3);
		hc <= 4'h0;
		pl(3);
		@(negedge i_clk);
		`CHK(4'h8, {hlt, osc, pce, run}, "halt entry")
		`CHK(MASK_LVL0, pm, "forced mask")
		@(posedge i_clk);
		preq[8] <= 1'h1;
		preq[7] <= 1'h1;
		repeat (10) @(negedge i_clk);
		`CHK(1'h1, hlt, "no wake")
		@(posedge i_clk);
		preq[8]      <= 1'h0;
		wc.spi_slave <= 1'h1;
		wt(2, 20);
		wt(1, 300);
		`CHK(256, nc, "short start-up")
		gr(4'h7);
		@(posedge i_clk);
		hc.startup_long <= 1'h1;
		pl(3);
		grp[2] <= 1'h0;
		wt(2, 20);
		wt(1, 4200);
		`CHK(4096, nc, "long start-up")
		gr(4'h4);
		@(posedge i_clk);
		hc.startup_long <= 1'h0;
		pl(3);
		preq[13] <= 1'h1;
		repeat (10) @(negedge i_clk);
		`CHK(1'h1, hlt, "no wake on internal clock")
		@(posedge i_clk);
		wc.art_ext_clk <= 1'h1;
		wt(2, 20);
		wt(1, 300);
		`CHK(256, nc, "short start-up again")
		gr(4'hD);
		pl(3);
		repeat (4) @(negedge i_clk);
		`CHK(1'h1, hlt, "halt before reset")
		@(posedge i_clk);
		i_rst <= 1'h1;
		repeat (6) @(posedge i_clk);
		i_rst <= 1'h0;
		wt(3, 300);
		`CHK(18'h1FFFE, {hlt, run, vec}, "reset ends halt")
		`CHK(257, nc, "reset start-up after halt")
	endtask : t_halt

	task automatic end_sim();
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	initial begin
		repeat (5) @(posedge i_clk);
		@(negedge i_clk);
		`CHK(18'h3FFFE, {pm, vec}, "reset outputs")
		@(posedge i_clk);
		i_rst <= 1'h0;
		wt(3, 300);
		`CHK(16'hFFFE, vec, "reset fetch")
		`CHK(257, nc, "reset start-up")
		t_ext();
		t_prio();
		t_clear();
		t_halt();
		end_sim();
	end
endmodule : testbench

`default_nettype wire
